// file: fault_history_log_tb.sv
// fault_history_log_tb: self-checking bench for fhl_log
// assumes the master model fhl_master and a free-running 40 MHz clock
`timescale 1ns/10ps
`default_nettype none
module fault_history_log_tb;
  import fhl_pkg::*;
  logic clock, rst, ce, power_on_pulse, fault_valid, par_rd, par_wr, par_ack, fault_stop;
  logic [15:0] par_addr;
  logic [31:0] par_wdata, par_rdata, rd;
  fhl_entry_t fin; // fault snapshot driven into the log
  fhl_entry_t rows [5]; // stored entries, oldest first
  logic ok, done;
  int bad_count = 0;
  int comparisons = 0;
  int i;
  fhl_log #(.depth(16), .aw(4)) dut (.clock(clock), .rst(rst), .ce(ce),
    .power_on_pulse(power_on_pulse), .fault_valid(fault_valid),
    .fault_severity_class(fin.severity), .fault_number(fin.number),
    .fault_qual_in(fin.qualifier), .fault_current_in(fin.current),
    .fault_speed_in(fin.speed), .fault_stage_temp_in(fin.stage_temp),
    .fault_dev_temp_in(fin.dev_temp), .par_rd(par_rd), .par_wr(par_wr),
    .par_addr(par_addr), .par_wdata(par_wdata), .par_rdata(par_rdata),
    .par_ack(par_ack), .fault_stop(fault_stop));
  fhl_master master (.clock(clock), .par_rd(par_rd), .par_wr(par_wr), .par_addr(par_addr),
    .par_wdata(par_wdata), .par_rdata(par_rdata), .par_ack(par_ack));
  // 25 ns clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  // one access; a missing answer ends the run
  task automatic acc(input logic wr, input logic [15:0] a, input logic [31:0] wd);
    master.access(wr, a, wd, rd, ok);
    if (!ok) begin
      bad_count++;
      print_verdict();
    end
  endtask : acc
  // read a 16-bit field, low half compared
  task automatic rd16(input string name, input logic [15:0] a, input logic [15:0] exp);
    acc(1'b0, a, 32'h0);
    check(name, {16'h0, rd[15:0]}, {16'h0, exp});
  endtask : rd16
  // one fault event, then time for it to land
  task automatic inject(input fhl_entry_t e);
    @(posedge clock);
    fin <= e;
    fault_valid <= 1'b1;
    @(posedge clock);
    fault_valid <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : inject
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    power_on_pulse = 1'b0;
    fault_valid = 1'b0;
    fin = '0;
    // severity, number, qualifier, current, speed, stage temp, device temp
    rows[0] = {3'h0, 16'h0000, 16'h3b08, 16'h0000, 16'h0000, 16'h0019, 16'h0014};
    rows[1] = {3'h1, 16'hffff, 16'hffff, 16'hffff, 16'h7fff, 16'h007d, 16'h0046};
    rows[2] = {3'h2, 16'h1234, 16'h0001, 16'h03e8, 16'h8000, 16'hffd8, 16'hffec};
    rows[3] = {3'h3, 16'h8001, 16'h5a5a, 16'h0001, 16'hfc18, 16'h8000, 16'h7fff};
    rows[4] = {3'h4, 16'h0002, 16'ha5a5, 16'h00fa, 16'h0064, 16'h0000, 16'h0000};
    repeat (2) @(posedge clock);
    #1;
    check("reset rdata", par_rdata, 32'h0);
    check("reset ack", {31'h0, par_ack}, 32'h0);
    check("reset stop", {31'h0, fault_stop}, 32'h0);
    // release on an edge so the first request meets a settled block
    @(posedge clock);
    rst <= 1'b0;
    // three power-on cycles counted, not writable
    for (i = 0; i < 3; i++) begin
      @(posedge clock);
      power_on_pulse <= 1'b1;
      @(posedge clock);
      power_on_pulse <= 1'b0;
    end
    // a pulse while ce is low must not count: all state is frozen
    @(posedge clock);
    ce <= 1'b0;
    power_on_pulse <= 1'b1;
    @(posedge clock);
    ce <= 1'b1;
    power_on_pulse <= 1'b0;
    acc(1'b1, off_power_on, 32'h0);
    acc(1'b0, off_power_on, 32'h0);
    check("power on count", rd, 32'h3);
    inject(rows[0]);
    check("warning stop", {31'h0, fault_stop}, 32'h0);
    for (i = 1; i < 5; i++) inject(rows[i]);
    check("error stop", {31'h0, fault_stop}, 32'h1);
    // table: each entry read in order through the advancing pointer
    for (i = 0; i < 5; i++) begin
      rd16("entry number", off_entry_num, rows[i].number);
      rd16("class", off_class, {13'h0, rows[i].severity});
      rd16("qualifier", off_qual, rows[i].qualifier);
      rd16("speed", off_speed, rows[i].speed);
      rd16("current", off_current, rows[i].current);
      rd16("stage temp", off_stage_temp, rows[i].stage_temp);
      rd16("device temp", off_dev_temp, rows[i].dev_temp);
    end
    acc(1'b0, 16'h3c20, 32'h0);
    check("unmapped", rd, 32'h0);
    acc(1'b1, off_rewind, 32'h1);
    rd16("rewound", off_entry_num, rows[0].number);
    acc(1'b1, off_rewind, 32'h2);
    rd16("rewind other", off_entry_num, rows[1].number);
    acc(1'b1, off_clear, 32'h0);
    rd16("clear other", off_entry_num, rows[2].number);
    acc(1'b1, off_clear, 32'h1);
    master.poll_clear(done);
    check("clear done", {31'h0, done}, 32'h1);
    check("erase stop", {31'h0, fault_stop}, 32'h0);
    // after erase the only entry is the new one
    inject(rows[3]);
    acc(1'b1, off_rewind, 32'h1);
    rd16("after erase", off_entry_num, rows[3].number);
    // out-of-range class is stored as the top code
    rows[4].severity = 3'h7;
    inject(rows[4]);
    rd16("clamp number", off_entry_num, rows[4].number);
    rd16("class clamp", off_class, {13'h0, class_max});
    // fill past depth: the newest entry overwrites the oldest slot
    for (i = 0; i < 15; i++) inject(rows[0]);
    acc(1'b1, off_rewind, 32'h1);
    rd16("oldest after wrap", off_entry_num, rows[4].number);
    print_verdict();
  end
endmodule : fault_history_log_tb
`default_nettype wire

// file: fhl_log.sv
// fault history log top: parameter access, entry capture and read buffer
// assumes one parameter access per strobe, synchronous to clock
`timescale 1ns/10ps
`default_nettype none
module fhl_log #(
  parameter int unsigned depth = 16,
  parameter int unsigned aw = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce, // freezes all state while low
  input wire logic power_on_pulse, // one pulse per power-on cycle
  input wire logic fault_valid, // one-cycle fault event
  input wire logic [2:0] fault_severity_class,
  input wire logic [15:0] fault_number,
  input wire logic [15:0] fault_qual_in,
  input wire logic [15:0] fault_current_in,
  input wire logic [15:0] fault_speed_in,
  input wire logic [15:0] fault_stage_temp_in,
  input wire logic [15:0] fault_dev_temp_in,
  input wire logic par_rd, // read strobe
  input wire logic par_wr, // write strobe
  input wire logic [fhl_pkg::addr_w-1:0] par_addr,
  input wire logic [fhl_pkg::data_w-1:0] par_wdata,
  output logic [fhl_pkg::data_w-1:0] par_rdata,
  output logic par_ack,
  output logic fault_stop // high when a stored class needs a reaction
);
  import fhl_pkg::*;

  typedef enum logic [1:0] {
    st_idle = 2'b01, // normal operation
    st_erase = 2'b10 // clearing slots one per cycle
  } fhl_state_t;

  fhl_mem_if #(.aw(aw)) mem ();

  fhl_store #(.depth(depth), .aw(aw)) u_store (
    .clock(clock),
    .ce(ce),
    .mem(mem.store)
  );

  // wrap a slot index
  function automatic logic [aw-1:0] inc_slot(input logic [aw-1:0] s);
    inc_slot = (s == aw'(depth - 1)) ? '0 : s + aw'(1);
  endfunction : inc_slot

  fhl_state_t state_reg, state_next;
  logic [aw-1:0] wr_ptr_reg, wr_ptr_next; // next slot to fill
  logic [aw-1:0] rd_ptr_reg, rd_ptr_next; // next entry to read
  logic [aw-1:0] oldest_reg, oldest_next; // oldest stored entry
  logic [aw:0] count_reg, count_next; // entries held
  logic [aw-1:0] erase_reg, erase_next; // erase sweep index
  logic [31:0] pwr_reg, pwr_next; // power-on cycle count
  fhl_entry_t hold_reg, hold_next; // holding buffer for field reads
  logic [31:0] rdata_reg, rdata_next;
  logic ack_reg, ack_next;
  logic stop_reg, stop_next;
  logic rd_num, wr_clr, wr_rew;

  assign rd_num = par_rd && (par_addr == off_entry_num);
  assign wr_clr = par_wr && (par_addr == off_clear);
  assign wr_rew = par_wr && (par_addr == off_rewind);

  // next-state for pointers, buffer and bus answer
  always_comb begin
    state_next = state_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    oldest_next = oldest_reg;
    count_next = count_reg;
    erase_next = erase_reg;
    pwr_next = pwr_reg;
    hold_next = hold_reg;
    rdata_next = rdata_reg;
    ack_next = par_rd || par_wr;
    stop_next = stop_reg;
    mem.we = 1'b0;
    mem.waddr = wr_ptr_reg;
    mem.wdata = '0;
    mem.raddr = rd_ptr_reg;
    if (power_on_pulse) begin
      pwr_next = pwr_reg + 32'h1;
    end
    unique case (state_reg)
      st_idle: begin
        // capture a fault with its snapshots
        if (fault_valid) begin
          mem.we = 1'b1;
          mem.wdata.severity = (fault_severity_class > class_max) ? class_max
                               : fault_severity_class;
          mem.wdata.number = fault_number;
          mem.wdata.qualifier = fault_qual_in;
          mem.wdata.current = fault_current_in;
          mem.wdata.speed = fault_speed_in;
          mem.wdata.stage_temp = fault_stage_temp_in;
          mem.wdata.dev_temp = fault_dev_temp_in;
          if (mem.wdata.severity != fhl_warning) begin
            stop_next = 1'b1;
          end
          wr_ptr_next = inc_slot(wr_ptr_reg);
          if (count_reg == (aw+1)'(depth)) begin
            oldest_next = inc_slot(oldest_reg); // overwrite oldest when full
          end else begin
            count_next = count_reg + (aw+1)'(1);
          end
        end
        if (rd_num) begin
          hold_next = mem.rdata;
          rd_ptr_next = inc_slot(rd_ptr_reg);
        end
        if (wr_rew && par_wdata[15:0] == cmd_go) begin
          rd_ptr_next = oldest_reg;
        end
        if (wr_clr && par_wdata[15:0] == cmd_go) begin
          state_next = st_erase;
          erase_next = '0;
        end
      end
      st_erase: begin
        // zero one slot per cycle; faults arriving now are dropped
        mem.we = 1'b1;
        mem.waddr = erase_reg;
        erase_next = inc_slot(erase_reg);
        if (erase_reg == aw'(depth - 1)) begin
          state_next = st_idle;
          wr_ptr_next = '0;
          rd_ptr_next = '0;
          oldest_next = '0;
          count_next = '0;
          hold_next = '0;
          stop_next = 1'b0;
        end
      end
      default: begin
        state_next = st_idle;
      end
    endcase
    // read mux
    if (par_rd) begin
      unique case (par_addr)
        off_power_on: rdata_next = pwr_reg;
        off_clear: rdata_next = {31'h0, state_reg == st_erase};
        off_rewind: rdata_next = '0;
        off_class: rdata_next = {29'h0, hold_reg.severity};
        off_entry_num: rdata_next = {16'h0, mem.rdata.number};
        off_qual: rdata_next = {16'h0, hold_reg.qualifier};
        off_speed: rdata_next = {16'h0, hold_reg.speed};
        off_current: rdata_next = {16'h0, hold_reg.current};
        off_stage_temp: rdata_next = {16'h0, hold_reg.stage_temp};
        off_dev_temp: rdata_next = {16'h0, hold_reg.dev_temp};
        default: rdata_next = '0;
      endcase
    end
  end

  // state registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= st_idle;
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      oldest_reg <= '0;
      count_reg <= '0;
      erase_reg <= '0;
      pwr_reg <= '0;
      hold_reg <= '0;
      rdata_reg <= '0;
      ack_reg <= 1'b0;
      stop_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      oldest_reg <= oldest_next;
      count_reg <= count_next;
      erase_reg <= erase_next;
      pwr_reg <= pwr_next;
      hold_reg <= hold_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
      stop_reg <= stop_next;
    end
  end

  assign par_rdata = rdata_reg;
  assign par_ack = ack_reg;
  assign fault_stop = stop_reg;

  property p_advance;
    @(posedge clock) disable iff (rst)
      (ce && state_reg == st_idle && rd_num && !wr_rew)
      |=> rd_ptr_reg == inc_slot($past(rd_ptr_reg));
  endproperty
  a_advance: assert property (p_advance) else $error("read pointer did not advance");

  property p_rewind;
    @(posedge clock) disable iff (rst)
      (ce && state_reg == st_idle && wr_rew && par_wdata[15:0] == cmd_go)
      |=> rd_ptr_reg == $past(oldest_reg);
  endproperty
  a_rewind: assert property (p_rewind) else $error("rewind failed");

  sequence s_clr;
    ce && state_reg == st_idle && wr_clr && par_wdata[15:0] == cmd_go;
  endsequence
  property p_erase;
    @(posedge clock) disable iff (rst || !ce)
      s_clr |=> ##[1:64] (state_reg == st_idle && count_reg == '0);
  endproperty
  a_erase: assert property (p_erase) else $error("erase did not finish");

  property p_clear_zero;
    @(posedge clock) disable iff (rst)
      (ce && par_rd && par_addr == off_clear && state_reg == st_idle)
      |=> par_rdata == '0;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear read not zero");

  property p_no_effect;
    @(posedge clock) disable iff (rst)
      (ce && state_reg == st_idle && wr_rew && par_wdata[15:0] != cmd_go
       && !rd_num) |=> $stable(rd_ptr_reg);
  endproperty
  a_no_effect: assert property (p_no_effect) else $error("rewind acted on bad value");

  property p_pwr;
    @(posedge clock) disable iff (rst)
      (ce && power_on_pulse) |=> pwr_reg == $past(pwr_reg) + 32'h1;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power count wrong");

  property p_latch;
    @(posedge clock) disable iff (rst)
      (ce && state_reg == st_idle && rd_num) |=> hold_reg == $past(mem.rdata);
  endproperty
  a_latch: assert property (p_latch) else $error("entry not latched");

  property p_class;
    @(posedge clock) disable iff (rst)
      mem.we && state_reg == st_idle |-> mem.wdata.severity <= class_max;
  endproperty
  a_class: assert property (p_class) else $error("class out of range");
endmodule : fhl_log
`default_nettype wire

// file: fhl_master.sv
// fhl_master: fieldbus master model for the fault history log
// assumes one-cycle strobes answered by par_ack one cycle later
`timescale 1ns/10ps
`default_nettype none
module fhl_master (
  input wire logic clock,
  output logic par_rd,
  output logic par_wr,
  output logic [15:0] par_addr,
  output logic [31:0] par_wdata,
  input wire logic [31:0] par_rdata,
  input wire logic par_ack
);
  // idle bus at time zero
  initial begin
    par_rd = 1'b0;
    par_wr = 1'b0;
    par_addr = 16'h0000;
    par_wdata = 32'h0;
  end
  // one access; address held until the answer, then inverted so it is never stale
  task automatic access(input logic wr, input logic [15:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 32'hffff_ffff;
    @(posedge clock);
    par_rd <= ~wr;
    par_wr <= wr;
    par_addr <= a;
    par_wdata <= wd;
    @(posedge clock);
    par_rd <= 1'b0;
    par_wr <= 1'b0;
    // bounded wait for the answer
    for (n = 0; n < 4 && !ok; n++) begin
      @(posedge clock);
      if (par_ack === 1'b1) begin
        ok = 1'b1;
        rd = par_rdata;
      end
    end
    par_addr <= ~a;
    par_wdata <= ~wd;
  endtask : access
  task automatic poll_clear(output logic done);
    logic [31:0] v;
    logic ok;
    int i;
    done = 1'b0;
    for (i = 0; i < 64 && !done; i++) begin
      access(1'b0, fhl_pkg::off_clear, 32'h0, v, ok);
      done = ok && (v[15:0] === 16'h0000);
    end
  endtask : poll_clear
endmodule : fhl_master
`default_nettype wire

// file: fhl_mem_if.sv
// fault history log: interface between the control top and the entry store
// assumes both ends share one clock
`timescale 1ns/10ps
`default_nettype none
interface fhl_mem_if #(parameter int unsigned aw = 4);
  import fhl_pkg::*;
  logic we; // write an entry
  logic [aw-1:0] waddr; // write slot
  fhl_entry_t wdata; // entry to write
  logic [aw-1:0] raddr; // read slot
  fhl_entry_t rdata; // entry at read slot
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : fhl_mem_if
`default_nettype wire

// file: fhl_pkg.sv
// fault history log package: register offsets, field widths, class codes
// assumes a simple parameter-access port; offsets are 16-bit parameter addresses
package fhl_pkg;
  localparam int unsigned addr_w = 16; // parameter address width
  localparam int unsigned data_w = 32; // read/write data width
  localparam logic [15:0] off_power_on = 16'h3b04;
  localparam logic [15:0] off_clear = 16'h3b08;
  localparam logic [15:0] off_rewind = 16'h3b0a;
  localparam logic [15:0] off_class = 16'h3c00;
  localparam logic [15:0] off_entry_num = 16'h3c02;
  localparam logic [15:0] off_qual = 16'h3c08;
  localparam logic [15:0] off_speed = 16'h3c10;
  localparam logic [15:0] off_current = 16'h3c12;
  localparam logic [15:0] off_stage_temp = 16'h3c14;
  localparam logic [15:0] off_dev_temp = 16'h3c16;
  // trigger value for clear and rewind parameters
  localparam logic [15:0] cmd_go = 16'h0001;
  // severity classes, higher is worse
  typedef enum logic [2:0] {
    fhl_warning = 3'h0,
    fhl_quick_stop = 3'h1,
    fhl_stop_89 = 3'h2,
    fhl_fatal_ack = 3'h3,
    fhl_fatal_noack = 3'h4
  } fhl_class_t;
  localparam logic [2:0] class_max = 3'h4;
  // one stored entry
  typedef struct packed {
    logic [2:0] severity;
    logic [15:0] number;
    logic [15:0] qualifier;
    logic [15:0] current;
    logic [15:0] speed;
    logic [15:0] stage_temp;
    logic [15:0] dev_temp;
  } fhl_entry_t;
endpackage : fhl_pkg

// file: fhl_store.sv
// fault history log entry store: a small array of entries
// assumes the controller never writes and reads the same slot in one cycle
`timescale 1ns/10ps
`default_nettype none
module fhl_store #(
  parameter int unsigned depth = 16,
  parameter int unsigned aw = 4
) (
  input wire logic clock,
  input wire logic ce,
  fhl_mem_if.store mem
);
  import fhl_pkg::*;
  // entry array, contents need no reset since occupancy is tracked outside
  fhl_entry_t slots [depth];
  // write port
  always_ff @(posedge clock) begin
    if (ce && mem.we) begin
      slots[mem.waddr] <= mem.wdata;
    end
  end
  // asynchronous read keeps the latch one cycle after the request
  assign mem.rdata = slots[mem.raddr];
endmodule : fhl_store
`default_nettype wire
